/* design/sptx_top.sv */
// transmit half of a serial port with parity, apb register slave
// Contract
// - parity is xor of data bits, inverted for odd parity
// - parity bit sits after last data bit, before first stop bit
// - parity bit inserted only when parity enable bit is one
// - transmit enable takes over the serial output pin
// - synchronous mode uses the external clock pin as bit clock; the master instead times bits from the baud generator and drives the pin
// - write to data register loads buffer and starts transmission
// - buffer moves to shifter when idle or right after last stop bit
// - shifter sends one frame at baud rate or external clock rate
// - unused upper data bits ignored for short characters
// - buffer empty flag high when buffer empty, low when holding data
// - data register write clears buffer empty flag
// - buffer empty interrupt requested while flag and enable are set
// - complete flag set when frame done and buffer empty
// - complete flag cleared by interrupt service or writing one
// - complete interrupt requested when flag set and enabled
// - clearing transmit enable waits until shifter and buffer are empty
// - once disabled, output pin returns to port control
// - low start, data lsb first, parity, one or two high stops
// - baud down-counter reloads at zero or on baud write, ticks at zero
// - tick divided by 16 normal, 8 double speed, 2 sync master
// - sync data changes on rising clock for polarity 0, falling for 1; the master instead drives a falling edge for 0, rising for 1
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "sptx_map.svh"
module sptx_top #(
   parameter int BAUD_W = `SPTX_BAUD_W
) (
   input  wire logic                   mclk,
   input  wire logic                   nrst,
   input  wire sptx_pkg::sptx_apb_req_t apb_req,
   output sptx_pkg::sptx_apb_rsp_t     apb_rsp,
   input  wire logic                   sync_clock_pin_i,
   output logic                        sync_clock_pin_o,
   output logic                        sync_clock_pin_oe,
   output logic                        txd_o,
   output logic                        txd_oe,
   input  wire logic                   irq_ack_ude,
   input  wire logic                   irq_ack_txc,
   output logic                        irq_ude,
   output logic                        irq_txc
);
   import sptx_pkg::*;

   sptx_state_rec_t s_q;
   sptx_state_rec_t s_d;

   // parity over the active character bits
   function automatic logic parity_of(input logic [8:0] d, input logic [2:0] csz, input logic odd);
      logic [8:0] m;
      m = 9'h1_FF;
      case (csz)
         3'h0:    m = 9'h0_1F;
         3'h1:    m = 9'h0_3F;
         3'h2:    m = 9'h0_7F;
         3'h3:    m = 9'h0_FF;
         `SPTX_CSZ_NINE: m = 9'h1_FF;
         default: m = 9'h0_FF;
      endcase
      return (^(d & m)) ^ odd;
   endfunction

   function automatic logic [3:0] nbits(input logic [2:0] csz);
      case (csz)
         3'h0:    return 4'h5;
         3'h1:    return 4'h6;
         3'h2:    return 4'h7;
         `SPTX_CSZ_NINE: return 4'h9;
         default: return 4'h8;
      endcase
   endfunction

   // bit period length minus one, in baud ticks
   function automatic logic [4:0] reload_of(input logic sync, input logic dbl);
      if (sync) begin
         return `SPTX_DIV_SYNC - 5'h01;
      end else if (dbl) begin
         return `SPTX_DIV_DOUBLE - 5'h01;
      end
      return `SPTX_DIV_NORMAL - 5'h01;
   endfunction

   logic wr_acc;
   logic rd_acc;
   logic bit_tick;
   logic xck_rise;
   logic xck_fall;
   assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite & ~s_q.pready_lat;
   assign rd_acc = apb_req.psel & apb_req.penable & ~apb_req.pwrite & ~s_q.pready_lat;
   assign xck_rise = s_q.xs2 & ~s_q.xs3;
   assign xck_fall = ~s_q.xs2 & s_q.xs3;

   always_comb begin
      logic        busy;
      logic        bt;
      logic [31:0] rd;
      s_d = s_q;
      busy = (s_q.st != ST_IDLE);
      rd = 32'h0000_0000;
      s_d.xs1 = sync_clock_pin_i;
      s_d.xs2 = s_q.xs1;
      s_d.xs3 = s_q.xs2;
      s_d.pready_lat = 1'b0;
      s_d.rsp.pready = 1'b0;
      s_d.rsp.pslverr = 1'b0;
      s_d.rsp.prdata = 32'h0000_0000;
      // baud generator
      bt = 1'b0;
      if (s_q.bcnt == 12'h000) begin
         s_d.bcnt = s_q.baud;
         bt = 1'b1;
      end else begin
         s_d.bcnt = s_q.bcnt - 12'h001;
      end
      // bit clock selection
      bit_tick = 1'b0;
      if (s_q.sync && s_q.slave) begin
         bit_tick = s_q.pol ? xck_fall : xck_rise;
      end else if (bt) begin
         if (s_q.tcnt == 5'h00) begin
            s_d.tcnt = reload_of(s_q.sync, s_q.dbl);
            bit_tick = 1'b1;
         end else begin
            s_d.tcnt = s_q.tcnt - 5'h01;
         end
         if (s_q.sync && !s_q.slave && s_q.tcnt == 5'h01) begin
            s_d.xck_o = ~s_q.pol;
         end
      end
      if (s_q.sync && !s_q.slave && bit_tick) begin
         s_d.xck_o = s_q.pol; // master: data changes on active edge
      end
      s_d.xck_oe = s_q.sync & ~s_q.slave & s_q.tx_enable_bit_eff;
      // transmitter
      if (bit_tick) begin
         case (s_q.st)
            ST_START: begin
               s_d.txd = s_q.shf[0];
               s_d.shf = {1'b0, s_q.shf[8:1]};
               s_d.bitn = s_q.bitn - 4'h1;
               s_d.st = ST_DATA;
            end
            ST_DATA: begin
               if (s_q.bitn == 4'h0) begin
                  if (s_q.pen) begin
                     s_d.txd = s_q.par;
                     s_d.st = ST_PAR;
                  end else begin
                     s_d.txd = 1'b1;
                     s_d.st = ST_STOP1;
                  end
               end else begin
                  s_d.txd = s_q.shf[0];
                  s_d.shf = {1'b0, s_q.shf[8:1]};
                  s_d.bitn = s_q.bitn - 4'h1;
               end
            end
            ST_PAR: begin
               s_d.txd = 1'b1;
               s_d.st = ST_STOP1;
            end
            ST_STOP1: begin
               if (s_q.stop2) begin
                  s_d.st = ST_STOP2;
               end else begin
                  s_d.st = ST_IDLE;
               end
            end
            ST_STOP2: s_d.st = ST_IDLE;
            ST_IDLE: s_d.txd = 1'b1;
            default: s_d.st = ST_IDLE;
         endcase
         if ((s_q.st == ST_STOP2) || (s_q.st == ST_STOP1 && !s_q.stop2)) begin
            if (s_q.ude) begin
               s_d.tx_complete_flag = 1'b1;
            end
         end
      end
      // load shifter when idle or right after last stop bit
      if (s_q.tx_enable_bit_eff && !s_q.ude && (s_d.st == ST_IDLE) && (bit_tick || !busy)) begin
         s_d.shf = s_q.buf_data;
         s_d.par = parity_of(s_q.buf_data, s_q.csz, s_q.podd);
         s_d.bitn = nbits(s_q.csz);
         s_d.ude = 1'b1;
         s_d.st = ST_START;
         s_d.txd = 1'b0;
         // full start bit when leaving idle; after a stop bit the divider is already reloaded
         if (!busy && (!s_q.sync || !s_q.slave)) begin
            s_d.tcnt = reload_of(s_q.sync, s_q.dbl);
         end
         s_d.tx_complete_flag = 1'b0;
      end
      // interrupt service clears complete flag, set wins
      if (irq_ack_txc && !(s_d.tx_complete_flag && !s_q.tx_complete_flag)) begin
         s_d.tx_complete_flag = 1'b0;
      end
      // apb
      if (apb_req.psel && apb_req.penable && !s_q.pready_lat) begin
         s_d.pready_lat = 1'b1;
         s_d.rsp.pready = 1'b1;
      end
      if (wr_acc) begin
         case (apb_req.paddr)
            `SPTX_OFF_DATA: begin
               s_d.buf_data = {s_q.ninth, apb_req.pwdata[7:0]};
               s_d.ude = 1'b0;
            end
            `SPTX_OFF_STATUS: begin
               s_d.dbl = apb_req.pwdata[`SPTX_ST_DOUBLE];
               if (apb_req.pwdata[`SPTX_ST_TXC] && !(s_d.tx_complete_flag && !s_q.tx_complete_flag)) begin
                  s_d.tx_complete_flag = 1'b0;
               end
            end
            `SPTX_OFF_CTRL_B: begin
               s_d.ninth = apb_req.pwdata[`SPTX_CB_NINTH];
               s_d.csz[2] = apb_req.pwdata[`SPTX_CB_CSZ2];
               s_d.tx_enable_bit = apb_req.pwdata[`SPTX_CB_TX_ENABLE_BIT];
               s_d.udeie = apb_req.pwdata[`SPTX_CB_UDEIE];
               s_d.tx_complete_irq_enable = apb_req.pwdata[`SPTX_CB_TX_COMPLETE_IRQ_ENABLE];
            end
            `SPTX_OFF_CTRL_C: begin
               s_d.pol = apb_req.pwdata[`SPTX_CC_POL];
               s_d.csz[1:0] = apb_req.pwdata[`SPTX_CC_CSZ_LO+:2];
               s_d.stop2 = apb_req.pwdata[`SPTX_CC_STOP2];
               s_d.podd = apb_req.pwdata[`SPTX_CC_PODD];
               s_d.pen = apb_req.pwdata[`SPTX_CC_PEN];
               s_d.sync = apb_req.pwdata[`SPTX_CC_SYNC];
               s_d.slave = apb_req.pwdata[`SPTX_CC_SLAVE];
            end
            `SPTX_OFF_BAUD: begin
               s_d.baud = apb_req.pwdata[11:0];
               s_d.bcnt = apb_req.pwdata[11:0];
            end
            default: s_d.rsp.pslverr = 1'b1;
         endcase
      end
      if (rd_acc) begin
         case (apb_req.paddr)
            `SPTX_OFF_DATA:   rd = 32'h0000_0000;
            `SPTX_OFF_STATUS: begin
               rd[`SPTX_ST_DOUBLE] = s_q.dbl;
               rd[`SPTX_ST_UDE] = s_q.ude;
               rd[`SPTX_ST_TXC] = s_q.tx_complete_flag;
            end
            `SPTX_OFF_CTRL_B: begin
               rd[`SPTX_CB_NINTH] = s_q.ninth;
               rd[`SPTX_CB_CSZ2] = s_q.csz[2];
               rd[`SPTX_CB_TX_ENABLE_BIT] = s_q.tx_enable_bit;
               rd[`SPTX_CB_UDEIE] = s_q.udeie;
               rd[`SPTX_CB_TX_COMPLETE_IRQ_ENABLE] = s_q.tx_complete_irq_enable;
            end
            `SPTX_OFF_CTRL_C: begin
               rd[7:0] = {s_q.slave, s_q.sync, s_q.pen, s_q.podd, s_q.stop2, s_q.csz[1:0], s_q.pol};
            end
            `SPTX_OFF_BAUD:   rd[11:0] = s_q.baud;
            default: s_d.rsp.pslverr = 1'b1;
         endcase
         s_d.rsp.prdata = rd;
      end
      // enable: set at once, clear only once nothing is pending
      if (s_q.tx_enable_bit) begin
         s_d.tx_enable_bit_eff = 1'b1;
      end else if (!busy && s_q.ude && s_d.st == ST_IDLE) begin
         s_d.tx_enable_bit_eff = 1'b0;
      end
      s_d.txd_oe = s_d.tx_enable_bit_eff;
      s_d.irq_ude = s_d.ude & s_d.udeie;
      s_d.irq_txc = s_d.tx_complete_flag & s_d.tx_complete_irq_enable;
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         s_q <= '0;
         s_q.ude <= 1'b1;
         s_q.csz <= `SPTX_CSZ_RESET;
         s_q.txd <= 1'b1;
         s_q.st <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign apb_rsp = s_q.rsp;
   assign txd_o = s_q.txd;
   assign txd_oe = s_q.txd_oe;
   assign sync_clock_pin_o = s_q.xck_o;
   assign sync_clock_pin_oe = s_q.xck_oe;
   assign irq_ude = s_q.irq_ude;
   assign irq_txc = s_q.irq_txc;

   // a data write empties flag at once
   a_data_write_flag: assert property (@(posedge mclk) disable iff (!nrst)
      wr_acc && apb_req.paddr == `SPTX_OFF_DATA |=> !s_q.ude || s_q.st == ST_START) else $error("flag not cleared");
   a_reset_state: assert property (@(posedge mclk)
      !nrst |=> s_q.ude && !s_q.tx_complete_flag && !txd_oe) else $error("bad reset state");
   a_pin_release: assert property (@(posedge mclk) disable iff (!nrst)
      txd_oe && !s_q.tx_enable_bit && s_q.st != ST_IDLE |=> txd_oe) else $error("pin released early");
   a_pin_take: assert property (@(posedge mclk) disable iff (!nrst)
      s_q.tx_enable_bit |=> txd_oe) else $error("pin not taken");
   a_start_low: assert property (@(posedge mclk) disable iff (!nrst)
      s_q.st == ST_START |-> !txd_o) else $error("start bit not low");
   a_stop_high: assert property (@(posedge mclk) disable iff (!nrst)
      s_q.st == ST_STOP1 |-> txd_o) else $error("stop bit not high");
   a_parity_gate: assert property (@(posedge mclk) disable iff (!nrst)
      s_q.st == ST_PAR |-> s_q.pen && txd_o == s_q.par) else $error("parity wrong");
   a_irq_ude_lvl: assert property (@(posedge mclk) disable iff (!nrst)
      s_q.ude && s_q.udeie |=> irq_ude || !s_q.ude || !s_q.udeie) else $error("irq missing");
   a_txc_irq: assert property (@(posedge mclk) disable iff (!nrst)
      irq_txc |-> s_q.tx_complete_flag && s_q.tx_complete_irq_enable) else $error("spurious complete irq");
   a_idle_high: assert property (@(posedge mclk) disable iff (!nrst)
      s_q.st == ST_IDLE && $past(s_q.st) == ST_IDLE |-> txd_o) else $error("idle not high");
endmodule

/* inc/sptx_map.svh */
// register offsets, field positions and reset values of the serial transmitter
`ifndef SPTX_MAP_SVH
`define SPTX_MAP_SVH
`define SPTX_OFF_DATA      12'h000
`define SPTX_OFF_STATUS    12'h004
`define SPTX_OFF_CTRL_B    12'h008
`define SPTX_OFF_CTRL_C    12'h00C
`define SPTX_OFF_BAUD      12'h010
// status_register_a fields
`define SPTX_ST_DOUBLE     1
`define SPTX_ST_TXC        6
`define SPTX_ST_UDE        5
// control_register_b fields
`define SPTX_CB_NINTH      0
`define SPTX_CB_CSZ2       2
`define SPTX_CB_TX_ENABLE_BIT       3
`define SPTX_CB_UDEIE      5
`define SPTX_CB_TX_COMPLETE_IRQ_ENABLE      6
// control_register_c fields
`define SPTX_CC_POL        0
`define SPTX_CC_CSZ_LO     1
`define SPTX_CC_STOP2      3
`define SPTX_CC_PODD       4
`define SPTX_CC_PEN        5
`define SPTX_CC_SYNC       6
`define SPTX_CC_SLAVE      7
`define SPTX_CSZ_RESET     3'h3
`define SPTX_CSZ_NINE      3'h7
`define SPTX_DIV_NORMAL    5'h10
`define SPTX_DIV_DOUBLE    5'h08
`define SPTX_DIV_SYNC      5'h02
`define SPTX_BAUD_W        12
`endif

/* inc/sptx_pkg.sv */
// types of the serial transmitter
package sptx_pkg;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } sptx_apb_req_t;
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } sptx_apb_rsp_t;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_START = 3'b001,
      ST_DATA  = 3'b011,
      ST_PAR   = 3'b010,
      ST_STOP1 = 3'b110,
      ST_STOP2 = 3'b111
   } sptx_state_t;
   typedef struct packed {
      sptx_apb_rsp_t rsp;
      logic          pready_lat;
      logic [8:0]    buf_data;
      logic          ude;
      logic          tx_complete_flag;
      logic          tx_enable_bit;
      logic          tx_enable_bit_eff;
      logic          ninth;
      logic          udeie;
      logic          tx_complete_irq_enable;
      logic          dbl;
      logic [2:0]    csz;
      logic          pen;
      logic          podd;
      logic          stop2;
      logic          sync;
      logic          slave;
      logic          pol;
      logic [11:0]   baud;
      logic [11:0]   bcnt;
      logic [4:0]    tcnt;
      sptx_state_t   st;
      logic [8:0]    shf;
      logic [3:0]    bitn;
      logic          par;
      logic          txd;
      logic          txd_oe;
      logic          xck_o;
      logic          xck_oe;
      logic          irq_ude;
      logic          irq_txc;
      logic          xs1;
      logic          xs2;
      logic          xs3;
   } sptx_state_rec_t;
endpackage

/* bench/sptx_far_rx.sv */
// far-end serial receiver model sampling the transmit line
`timescale 1ns/1ps
module sptx_far_rx (
   input  wire logic        mclk,
   input  wire logic        line,
   input  wire logic [7:0]  bit_cyc,
   input  wire logic [3:0]  nb,
   output logic      [12:0] got,
   output logic      [7:0]  cnt
);
   logic prev;
   initial begin
      got = '0;
      cnt = '0;
      prev = 1'b1;
      forever begin
         @(posedge mclk);
         if (prev === 1'b1 && line === 1'b0) begin
            got = '0;
            // sample each bit near its centre
            repeat (bit_cyc / 2) @(posedge mclk);
            for (int i = 0; i < nb; i++) begin
               got[i] = line;
               if (i < nb - 1) repeat (bit_cyc) @(posedge mclk);
            end
            cnt = cnt + 8'h01;
         end
         prev = line;
      end
   end
endmodule

/* bench/tb_top.sv */
// self-checking bench for the serial transmitter
`timescale 1ns/1ps
`include "sptx_map.svh"
module tb_top;
   import sptx_pkg::*;
   logic          mclk;
   logic          nrst;
   sptx_apb_req_t req;
   sptx_apb_rsp_t rsp;
   logic          ck_i;
   logic          ck_o;
   logic          ck_oe;
   logic          ack_txc;
   logic          txd_o;
   logic          txd_oe;
   logic          irq_ude;
   logic          irq_txc;
   logic          line;
   logic [7:0]    bc;
   logic [3:0]    nb;
   logic [12:0]   got;
   logic [7:0]    cnt;
   logic [31:0]   rd;
   logic          er;
   int            err_count;
   int            checks;

   // pull-up while the pin is under port control
   assign line = txd_oe ? txd_o : 1'b1;

   sptx_top dut (.mclk(mclk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp), .sync_clock_pin_i(ck_i),
      .sync_clock_pin_o(ck_o), .sync_clock_pin_oe(ck_oe), .txd_o(txd_o), .txd_oe(txd_oe),
      .irq_ack_ude(1'b0), .irq_ack_txc(ack_txc), .irq_ude(irq_ude), .irq_txc(irq_txc));
   sptx_far_rx far (.mclk(mclk), .line(line), .bit_cyc(bc), .nb(nb), .got(got), .cnt(cnt));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH at %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= w;
      req.paddr <= a;
      req.pwdata <= d;
      @(posedge mclk);
      req.penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 50);
      if (n >= 50) chk(32'h0000_0000, 32'h0000_0001);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic wait_frames(input logic [7:0] t);
      int n;
      n = 0;
      while (cnt !== t && n < 2000) begin
         @(posedge mclk);
         n++;
      end
      chk(cnt, t);
   endtask

   function automatic logic [12:0] fr(logic [8:0] d, int n, bit pen, bit odd, int st);
      logic [12:0] b;
      logic        p;
      int          k;
      b = '0;
      p = odd;
      for (int i = 0; i < n; i++) begin
         b[1 + i] = d[i];
         p ^= d[i];
      end
      k = 1 + n;
      if (pen) begin
         b[k] = p;
         k++;
      end
      for (int i = 0; i < st; i++) b[k + i] = 1'b1;
      return b;
   endfunction

   // clear complete flag, send one character, compare the frame on the wire
   task automatic send(input logic [31:0] d, input int n, input bit pen, input bit odd, input int st);
      logic [7:0] t;
      t = cnt + 8'h01;
      nb = 4'(1 + n + pen + st);
      apb(1'b1, `SPTX_OFF_STATUS, 32'h0000_0040 | (rd & 32'h0000_0002));
      apb(1'b1, `SPTX_OFF_DATA, d);
      wait_frames(t);
      chk(32'(got), 32'(fr(d[8:0], n, pen, odd, st)));
      idle(40);
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #200us;
      err_count++;
      summarize();
   end

   initial begin
      err_count = 0;
      checks = 0;
      nrst = 1'b0;
      req = '0;
      ck_i = 1'b0;
      ack_txc = 1'b0;
      bc = 8'd32;
      nb = 4'd11;
      rd = '0;
      idle(3);
      nrst <= 1'b1;
      chk(32'(txd_oe), 32'h0000_0000);
      apb(1'b0, `SPTX_OFF_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_0060, 32'h0000_0020);
      apb(1'b0, 12'h020, 32'h0000_0000);
      chk(32'(er), 32'h0000_0001);
      chk(32'(irq_ude | irq_txc), 32'h0000_0000);
      $display("test reset done");
      apb(1'b1, `SPTX_OFF_CTRL_C, 32'h0000_0026);
      apb(1'b1, `SPTX_OFF_BAUD, 32'h0000_0001);
      apb(1'b1, `SPTX_OFF_CTRL_B, 32'h0000_0008);
      idle(2);
      chk(32'(txd_oe), 32'h0000_0001);
      apb(1'b1, `SPTX_OFF_DATA, 32'h0000_00A5);
      apb(1'b1, `SPTX_OFF_DATA, 32'h0000_003C);
      apb(1'b0, `SPTX_OFF_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_0060, 32'h0000_0000);
      wait_frames(8'd1);
      chk(32'(got), 32'(fr(9'h0A5, 8, 1, 0, 1)));
      wait_frames(8'd2);
      chk(32'(got), 32'(fr(9'h03C, 8, 1, 0, 1)));
      idle(40);
      apb(1'b0, `SPTX_OFF_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_0060, 32'h0000_0060);
      $display("test back to back done");
      apb(1'b1, `SPTX_OFF_CTRL_B, 32'h0000_0048);
      idle(2);
      chk(32'(irq_txc), 32'h0000_0001);
      ack_txc <= 1'b1;
      idle(1);
      ack_txc <= 1'b0;
      apb(1'b0, `SPTX_OFF_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_0040, 32'h0000_0000);
      apb(1'b1, `SPTX_OFF_CTRL_B, 32'h0000_0028);
      idle(2);
      chk(32'(irq_ude), 32'h0000_0001);
      apb(1'b1, `SPTX_OFF_CTRL_B, 32'h0000_0008);
      idle(2);
      chk(32'(irq_ude), 32'h0000_0000);
      $display("test flags done");
      rd = '0;
      apb(1'b1, `SPTX_OFF_CTRL_C, 32'h0000_0030);
      send(32'h0000_00EB, 5, 1, 1, 1);
      apb(1'b1, `SPTX_OFF_CTRL_C, 32'h0000_0026);
      apb(1'b1, `SPTX_OFF_CTRL_B, 32'h0000_000D);
      send(32'h0000_015A, 9, 1, 0, 1);
      apb(1'b1, `SPTX_OFF_CTRL_B, 32'h0000_0008);
      apb(1'b1, `SPTX_OFF_CTRL_C, 32'h0000_000E);
      send(32'h0000_0096, 8, 0, 0, 2);
      $display("test formats done");
      apb(1'b1, `SPTX_OFF_STATUS, 32'h0000_0002);
      bc = 8'd16;
      rd = 32'h0000_0002;
      send(32'h0000_0055, 8, 0, 0, 2);
      $display("test double speed done");
      rd = '0;
      bc = 8'd4;
      apb(1'b1, `SPTX_OFF_CTRL_C, 32'h0000_0046);
      idle(2);
      chk(32'(ck_oe), 32'h0000_0001);
      send(32'h0000_0069, 8, 0, 0, 1);
      apb(1'b1, `SPTX_OFF_CTRL_C, 32'h0000_000E);
      $display("test sync master done");
      bc = 8'd32;
      nb = 4'd11;
      apb(1'b1, `SPTX_OFF_DATA, 32'h0000_00C3);
      apb(1'b1, `SPTX_OFF_CTRL_B, 32'h0000_0000);
      chk(32'(txd_oe), 32'h0000_0001);
      wait_frames(cnt + 8'h01);
      chk(32'(got), 32'(fr(9'h0C3, 8, 0, 0, 2)));
      idle(40);
      chk(32'(txd_oe), 32'h0000_0000);
      $display("test disable done");
      summarize();
   end
endmodule
